// ---- hdl/tcs_scheduler.sv ----
// Conversion scheduler with interval, one-shot, ideality and identification registers.
// Assumes the two-wire front end delivers decoded pointer accesses and
// general-call events on clk; shutdown_request comes from configuration logic.
//
// Overview of operation
// - Interval read at 04h, written at 0Ah
// - Interval changes only the idle gap
// - Codes 00h..09h: 16 s halving down
// - Interval resets to 08h, sixteen per second
// - One-shot write in shutdown starts cycle
// - One-shot runs local and remote once
// - After one-shot, back to shutdown
// - One-shot data byte discarded
// - Ideality register 23h, signed eight bits
// - Ideality resets to zero, no effect
// - Remote scaled by (2088+N)/2088
// - Offset added to every remote result
// - Acknowledge general call, examine next byte
// - Byte 06h resets registers, aborts conversion
// - Other second bytes change nothing
// - Fixed maker code read at FEh
// - Shutdown finishes sequence; clear resumes converting
`timescale 1ns/1ps
`default_nettype none
module tcs_scheduler
  #(
  parameter int unsigned TICK_CYCLES = tcs_pkg::TICK_CYCLES_DFLT,
  parameter int unsigned CONV_CYCLES = tcs_pkg::CONV_CYCLES_DFLT,
  // Arbitrary identification value
  parameter logic [7:0]  MAKER_CODE  = 8'hA5
  )
  (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Pointer access from the two-wire front end
  input  wire tcs_pkg::tcs_reg_req_s        reg_req,
  output logic      [7:0]                   rd_data,
  // General call
  input  wire logic                         gc_addr_stb,
  input  wire logic                         gc_byte_stb,
  input  wire logic [7:0]                   gc_byte,
  output logic                              gc_ack,
  // Configuration
  input  wire logic                         shutdown_request,
  // Converter
  input  wire logic [tcs_pkg::RESULT_W-1:0] raw_local,
  input  wire logic [tcs_pkg::RESULT_W-1:0] raw_remote,
  input  wire logic [tcs_pkg::RESULT_W-1:0] remote_offset,
  output logic                              conv_busy,
  output logic                              conv_channel,
  // Results
  output logic      [tcs_pkg::RESULT_W-1:0] local_result,
  output logic      [tcs_pkg::RESULT_W-1:0] remote_result,
  output logic                              result_stb
  );
  import tcs_pkg::*;

  generate
    if (CONV_CYCLES < 4 || CONV_CYCLES > 4096) begin : g_bad_conv
      $error("CONV_CYCLES must lie in 4..4096");
    end
  endgenerate

  // Local channel fills the first half, remote the second
  localparam int unsigned HALF = CONV_CYCLES / 2;

  ////////////////////////////////////////////////////////////////////////////
  // General call and register file

  logic [7:0] interval_q, interval_d;
  logic [7:0] ideal_q, ideal_d;
  logic [7:0] rdata_q, rdata_d;
  logic       gc_ack_q, gc_ack_d;
  logic       gc_reset;
  logic       shot_wr;

  always_comb
  begin
    // Only a second byte that follows an acknowledged call counts
    gc_reset   = gc_ack_q && gc_byte_stb && (gc_byte == GC_RESET_CMD);
    // Byte value of a one-shot write is never looked at
    shot_wr    = reg_req.wr && (reg_req.ptr == PTR_ONE_SHOT);
    interval_d = interval_q;
    ideal_d    = ideal_q;
    rdata_d    = rdata_q;
    gc_ack_d   = gc_ack_q;
    if (gc_addr_stb)
      gc_ack_d = 1'b1;
    else if (gc_byte_stb)
      gc_ack_d = 1'b0;
    if (gc_reset)
    begin
      interval_d = INTERVAL_RST;
      ideal_d    = IDEALITY_RST;
      rdata_d    = UNMAPPED_RD;
    end
    else
    begin
      if (reg_req.wr)
      begin
        if (reg_req.ptr == PTR_INTERVAL_WR)
          interval_d = reg_req.data;
        else if (reg_req.ptr == PTR_IDEALITY)
          ideal_d = reg_req.data;
      end
      if (reg_req.rd)
      begin
        unique case (reg_req.ptr)
          PTR_INTERVAL_RD: rdata_d = interval_q;
          PTR_IDEALITY:    rdata_d = ideal_q;
          PTR_MAKER:       rdata_d = MAKER_CODE;
          default:         rdata_d = UNMAPPED_RD;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interval_q <= INTERVAL_RST;
      ideal_q    <= IDEALITY_RST;
      rdata_q    <= UNMAPPED_RD;
      gc_ack_q   <= 1'b0;
    end
    else
    begin
      interval_q <= interval_d;
      ideal_q    <= ideal_d;
      rdata_q    <= rdata_d;
      gc_ack_q   <= gc_ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  tcs_state_e          st_q, st_d;
  logic [12:0]         cnt_q, cnt_d;
  logic                shot_q, shot_d;
  logic                pend_q, pend_d;
  logic                busy_q, busy_d;
  logic                chan_q, chan_d;
  logic [RESULT_W-1:0] local_q, local_d;
  logic                gap_load;
  logic                gap_clear;
  logic                gap_done;
  logic                cal_stb;
  logic                cal_valid;

  always_comb
  begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    shot_d    = shot_q;
    local_d   = local_q;
    gap_load  = 1'b0;
    gap_clear = 1'b0;
    cal_stb   = 1'b0;
    // Request raised during shutdown survives the consumption cycle of an earlier one
    pend_d    = pend_q;
    if (shot_wr && shutdown_request)
      pend_d = 1'b1;
    // Leaving shutdown drops an unstarted one-shot, else it fires on the next shutdown
    else if (!shutdown_request)
      pend_d = 1'b0;
    if (gc_reset)
    begin
      // Abort: whatever was converting is dropped, nothing is published
      st_d      = ST_SHUT;
      cnt_d     = 13'h0000;
      shot_d    = 1'b0;
      pend_d    = 1'b0;
      local_d   = '0;
      gap_clear = 1'b1;
    end
    else
    begin
      unique case (st_q)
        ST_SHUT:
        begin
          if (!shutdown_request)
          begin
            st_d   = ST_CONV;
            cnt_d  = 13'h0000;
            shot_d = 1'b0;
          end
          else if (pend_q)
          begin
            st_d   = ST_CONV;
            cnt_d  = 13'h0000;
            shot_d = 1'b1;
            if (!(shot_wr && shutdown_request))
              pend_d = 1'b0;
          end
        end
        ST_CONV:
        begin
          // Conversion length is fixed; the interval never touches it
          cnt_d = cnt_q + 13'h0001;
          if (cnt_q == 13'(HALF - 1))
            local_d = raw_local;
          if (cnt_q == 13'(CONV_CYCLES - 1))
          begin
            cal_stb = 1'b1;
            cnt_d   = 13'h0000;
            if (shot_q || shutdown_request)
            begin
              st_d   = ST_SHUT;
              shot_d = 1'b0;
            end
            else
            begin
              st_d     = ST_GAP;
              gap_load = 1'b1;
            end
          end
        end
        ST_GAP:
        begin
          if (shutdown_request)
          begin
            st_d      = ST_SHUT;
            gap_clear = 1'b1;
          end
          else if (gap_done)
          begin
            st_d  = ST_CONV;
            cnt_d = 13'h0000;
          end
        end
        default:
        begin
          st_d = ST_SHUT;
        end
      endcase
    end
    busy_d = (st_d == ST_CONV);
    chan_d = (st_d == ST_CONV) && (cnt_d >= 13'(HALF));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q    <= ST_SHUT;
      cnt_q   <= 13'h0000;
      shot_q  <= 1'b0;
      pend_q  <= 1'b0;
      busy_q  <= 1'b0;
      chan_q  <= 1'b0;
      local_q <= '0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shot_q  <= shot_d;
      pend_q  <= pend_d;
      busy_q  <= busy_d;
      chan_q  <= chan_d;
      local_q <= local_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gap timer and remote correction

  tcs_gap_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_gap (
    .clk     (clk),
    .rst_b   (rst_b),
    .clear   (gap_clear),
    .load    (gap_load),
    .code    (interval_q),
    .expired (gap_done)
  );

  tcs_remote_cal u_cal (
    .clk    (clk),
    .rst_b  (rst_b),
    .clear  (gc_reset),
    .stb    (cal_stb),
    .raw    (raw_remote),
    .adjust (ideal_q),
    .offset (remote_offset),
    .result (remote_result),
    .valid  (cal_valid)
  );

  assign rd_data      = rdata_q;
  assign gc_ack       = gc_ack_q;
  assign conv_busy    = busy_q;
  assign conv_channel = chan_q;
  assign local_result = local_q;
  assign result_stb   = cal_valid;

endmodule
`default_nettype wire

// ---- hdl/tcs_pkg.sv ----
// Shared constants, types and helpers for the conversion scheduler.
// Assumes one 125 MHz clock; no bus of its own, pointers come from the two-wire front end.
package tcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer locations
  localparam logic [7:0] PTR_INTERVAL_RD = 8'h04;
  localparam logic [7:0] PTR_INTERVAL_WR = 8'h0A;
  localparam logic [7:0] PTR_ONE_SHOT    = 8'h0F;
  localparam logic [7:0] PTR_IDEALITY    = 8'h23;
  localparam logic [7:0] PTR_MAKER       = 8'hFE;

  // Values after reset and fixed answers
  localparam logic [7:0] INTERVAL_RST    = 8'h08;
  localparam logic [7:0] IDEALITY_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_RD     = 8'h00;
  localparam logic [7:0] GC_RESET_CMD    = 8'h06;
  localparam logic [7:0] INTERVAL_TOP    = 8'h09;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  // Base tick of the gap timer: shortest interval, 0.03125 s
  localparam int unsigned TICK_PERIOD_NS  = 31_250_000;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Code 00h gives 16 s, i.e. 512 base ticks
  localparam int unsigned GAP_TICKS_CODE0 = 512;
  localparam int unsigned CONV_CYCLES_DFLT = 1000;

  // Remote correction
  localparam int unsigned IDEAL_NOMINAL   = 2088;
  localparam int unsigned RESULT_W        = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ptr;
    logic [7:0] data;
  } tcs_reg_req_s;

  typedef enum logic [1:0] {
    ST_SHUT = 2'b00,
    ST_CONV = 2'b01,
    ST_GAP  = 2'b10
  } tcs_state_e;

  // Codes above the table clamp to the fastest rate
  function automatic logic [9:0] tcs_gap_ticks(input logic [7:0] code);
    logic [3:0] c;
    c = (code > INTERVAL_TOP) ? INTERVAL_TOP[3:0] : code[3:0];
    return 10'(GAP_TICKS_CODE0 >> c);
  endfunction

endpackage

// ---- hdl/tcs_gap_timer.sv ----
// Idle-gap timer: base-tick prescaler and tick down-counter.
// Assumes load and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tcs_gap_timer
  #(parameter int unsigned TICK_CYCLES = tcs_pkg::TICK_CYCLES_DFLT)
  (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [7:0] code,
  // Result
  output logic            expired
  );
  import tcs_pkg::*;

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  logic [31:0] pre_q, pre_d;
  logic [9:0]  left_q, left_d;
  logic        run_q, run_d;
  logic        exp_q, exp_d;

  always_comb
  begin
    pre_d  = pre_q;
    left_d = left_q;
    run_d  = run_q;
    exp_d  = 1'b0;
    if (clear)
    begin
      run_d  = 1'b0;
      pre_d  = 32'h0;
      left_d = 10'h000;
    end
    else if (load)
    begin
      // Prescaler restarts so the gap is a whole number of ticks
      run_d  = 1'b1;
      pre_d  = 32'h0;
      left_d = tcs_gap_ticks(code);
    end
    else if (run_q)
    begin
      if (pre_q == 32'(TICK_CYCLES - 1))
      begin
        pre_d = 32'h0;
        if (left_q == 10'h001)
        begin
          run_d  = 1'b0;
          exp_d  = 1'b1;
          left_d = 10'h000;
        end
        else
        begin
          left_d = left_q - 10'h001;
        end
      end
      else
      begin
        pre_d = pre_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_q  <= 32'h0;
      left_q <= 10'h000;
      run_q  <= 1'b0;
      exp_q  <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      left_q <= left_d;
      run_q  <= run_d;
      exp_q  <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule
`default_nettype wire

// ---- hdl/tcs_remote_cal.sv ----
// Remote result correction: ideality scaling then offset addition.
// Assumes raw is an unsigned absolute-referenced code sampled on stb.
`timescale 1ns/1ps
`default_nettype none
module tcs_remote_cal
  (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Control
  input  wire logic                         clear,
  input  wire logic                         stb,
  input  wire logic [tcs_pkg::RESULT_W-1:0] raw,
  input  wire logic [7:0]                   adjust,
  input  wire logic [tcs_pkg::RESULT_W-1:0] offset,
  // Result
  output logic      [tcs_pkg::RESULT_W-1:0] result,
  output logic                              valid
  );
  import tcs_pkg::*;

  logic [RESULT_W-1:0] res_q, res_d;
  logic                val_q, val_d;
  logic signed [13:0]  denom;
  logic signed [27:0]  prod;
  logic signed [27:0]  quot;
  logic signed [27:0]  sum;

  // Reading scales by 1.008/eta_eff = (2088 + N) / 2088
  always_comb
  begin
    denom = 14'(IDEAL_NOMINAL) + 14'(signed'(adjust));
    prod  = 28'(signed'({1'b0, raw})) * 28'(denom);
    quot  = prod / 28'(IDEAL_NOMINAL);
    sum   = quot + 28'(signed'(offset));
    res_d = res_q;
    val_d = 1'b0;
    if (clear)
    begin
      res_d = '0;
    end
    else if (stb)
    begin
      val_d = 1'b1;
      // Clamp rather than wrap: a wrapped reading would look cold
      if (sum < 28'sh0)
        res_d = '0;
      else if (sum > 28'sh0000FFF)
        res_d = '1;
      else
        res_d = sum[RESULT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      res_q <= '0;
      val_q <= 1'b0;
    end
    else
    begin
      res_q <= res_d;
      val_q <= val_d;
    end
  end

  assign result = res_q;
  assign valid  = val_q;

endmodule
`default_nettype wire

// ---- testbench/tcs_sched_props.sv ----
// Checker for the conversion scheduler top ports.
// Assumes binding to tcs_scheduler with its own parameters.
`timescale 1ns/1ps
`default_nettype none
module tcs_sched_props
  #(
  parameter int unsigned CONV_CYCLES = tcs_pkg::CONV_CYCLES_DFLT,
  parameter logic [7:0]  MAKER_CODE  = 8'hA5
  )
  (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Host side
  input  wire tcs_pkg::tcs_reg_req_s reg_req,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  gc_addr_stb,
  input  wire logic                  gc_byte_stb,
  input  wire logic [7:0]            gc_byte,
  input  wire logic                  gc_ack,
  // Conversion
  input  wire logic                  shutdown_request,
  input  wire logic                  conv_busy,
  input  wire logic                  conv_channel,
  input  wire logic                  result_stb
  );
  import tcs_pkg::*;
  logic [12:0] busy_cnt_q;
  logic [12:0] busy_cnt_d;
  logic        os_wr;
  logic        gc_rst;
  ////////////////////////////////////////////////////////////////////////////
  assign os_wr  = reg_req.wr && reg_req.ptr == PTR_ONE_SHOT;
  assign gc_rst = gc_ack && gc_byte_stb && gc_byte == GC_RESET_CMD;
  always_comb busy_cnt_d = conv_busy ? busy_cnt_q + 13'h1 : 13'h0;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      busy_cnt_q <= 13'h0;
    else
      busy_cnt_q <= busy_cnt_d;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_rise_a: assert property (gc_addr_stb |=> gc_ack)
    else $error("general call not acknowledged");
  ack_drop_a: assert property (gc_ack && gc_byte_stb && !gc_addr_stb |=> !gc_ack)
    else $error("general call ack held");
  gc_reset_a: assert property (gc_rst |=> !conv_busy && rd_data == 8'h00)
    else $error("general call reset incomplete");
  conv_len_a: assert property ($fell(conv_busy) && !$past(gc_byte_stb) |-> busy_cnt_q == CONV_CYCLES)
    else $error("conversion length wrong");
  end_stb_a: assert property ($fell(conv_busy) && !$past(gc_byte_stb) |-> result_stb)
    else $error("no result at conversion end");
  stb_at_end_a: assert property (result_stb |-> $fell(conv_busy))
    else $error("result outside conversion end");
  chan_busy_a: assert property (conv_channel |-> conv_busy)
    else $error("channel set while idle");
  maker_rd_a: assert property (reg_req.rd && reg_req.ptr == PTR_MAKER && !gc_byte_stb
    |=> rd_data == MAKER_CODE)
    else $error("maker code wrong");
  wr_ptr_rd_a: assert property (reg_req.rd && reg_req.ptr == PTR_INTERVAL_WR
    && !gc_byte_stb |=> rd_data == 8'h00)
    else $error("write pointer readable");
  shut_hold_a: assert property (shutdown_request && !conv_busy && !$past(conv_busy)
    && !os_wr && !$past(os_wr) |=> !conv_busy)
    else $error("conversion while shut down");
  cover property (gc_rst);
  cover property (os_wr && shutdown_request ##[1:4] conv_busy);
  cover property (result_stb);
endmodule
bind tcs_scheduler tcs_sched_props #(.CONV_CYCLES(CONV_CYCLES), .MAKER_CODE(MAKER_CODE)) i_props (
  .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
  .gc_addr_stb(gc_addr_stb), .gc_byte_stb(gc_byte_stb), .gc_byte(gc_byte), .gc_ack(gc_ack),
  .shutdown_request(shutdown_request), .conv_busy(conv_busy), .conv_channel(conv_channel),
  .result_stb(result_stb));
`default_nettype wire

// ---- testbench/tcs_host_model.sv ----
// Two-wire host model: pointer accesses and general calls.
// Assumes callers wait for reset release; drives 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model
  (
  // Clock
  input  wire logic             clk,
  // Requests
  output tcs_pkg::tcs_reg_req_s reg_req,
  output logic                  gc_addr_stb,
  output logic                  gc_byte_stb,
  output logic [7:0]            gc_byte,
  // Answer
  input  wire logic [7:0]       rd_data
  );
  initial
  begin
    reg_req     = '0;
    gc_addr_stb = 1'b0;
    gc_byte_stb = 1'b0;
    gc_byte     = 8'h00;
  end
  // Released lines show inverted values so stale data cannot pass
  task automatic access(input logic w, input logic r, input logic [7:0] p,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_req = '{wr: w, rd: r, ptr: p, data: d};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, ptr: ~p, data: ~d};
    q = rd_data;
  endtask
  task automatic gcall(input logic [7:0] b);
    @(posedge clk);
    #1;
    gc_addr_stb = 1'b1;
    @(posedge clk);
    #1;
    gc_addr_stb = 1'b0;
    gc_byte_stb = 1'b1;
    gc_byte     = b;
    @(posedge clk);
    #1;
    gc_byte_stb = 1'b0;
    gc_byte     = ~b;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the conversion scheduler.
// Assumes tcs_host_model owns the register and general-call ports.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcs_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary identification value
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         shutdown_request = 1'b0;
  logic [11:0]  raw_local = 12'h0;
  logic [11:0]  raw_remote = 12'h0;
  logic [11:0]  remote_offset = 12'h0;
  tcs_reg_req_s reg_req;
  logic [7:0]   rd_data;
  logic [7:0]   gc_byte;
  logic [7:0]   q;
  logic         gc_addr_stb;
  logic         gc_byte_stb;
  logic         gc_ack;
  logic         conv_busy;
  logic         conv_channel;
  logic         result_stb;
  logic [11:0]  local_result;
  logic [11:0]  remote_result;
  int           failures = 0;
  int           n_compared = 0;
  int           n_remote = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  tcs_host_model i_host (.clk(clk), .reg_req(reg_req), .gc_addr_stb(gc_addr_stb),
    .gc_byte_stb(gc_byte_stb), .gc_byte(gc_byte), .rd_data(rd_data));
  // Short tick and conversion keep the 16 s gap to 2049 cycles
  tcs_scheduler #(.TICK_CYCLES(4), .CONV_CYCLES(8), .MAKER_CODE(MAKER)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
    .gc_addr_stb(gc_addr_stb), .gc_byte_stb(gc_byte_stb), .gc_byte(gc_byte),
    .gc_ack(gc_ack), .shutdown_request(shutdown_request), .raw_local(raw_local),
    .raw_remote(raw_remote), .remote_offset(remote_offset), .conv_busy(conv_busy),
    .conv_channel(conv_channel), .local_result(local_result), .remote_result(remote_result),
    .result_stb(result_stb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.access(1'b1, 1'b0, p, d, q);
  endtask
  task automatic rd(input logic [7:0] p, input string what, input logic [7:0] exp);
    i_host.access(1'b0, 1'b1, p, 8'h00, q);
    check(what, 12'(exp), 12'(q));
  endtask
  task automatic span(input logic v, output int n);
    n = 0;
    n_remote = 0;
    while (conv_busy === v)
    begin
      if (conv_channel === 1'b1) n_remote++;
      step;
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(PTR_INTERVAL_RD, "interval reset", INTERVAL_RST);
    rd(PTR_IDEALITY, "ideality reset", IDEALITY_RST);
    rd(PTR_MAKER, "maker", MAKER);
    wr(PTR_INTERVAL_RD, 8'h03);
    rd(PTR_INTERVAL_WR, "write pointer", 8'h00);
    rd(PTR_INTERVAL_RD, "read pointer", INTERVAL_RST);
    wr(PTR_IDEALITY, 8'h80);
    rd(PTR_IDEALITY, "ideality", 8'h80);
  endtask
  task automatic t_gap;
    int n;
    // Code 0Ah lies above the table and must decode as the fastest rate
    for (int c = 0; c < 11; c++)
    begin
      wr(PTR_INTERVAL_WR, 8'(c));
      while (conv_busy !== 1'b0) step;
      while (conv_busy !== 1'b1) step;
      span(1'b1, n);
      span(1'b0, n);
      check("gap", 12'(((512 >> (c > 9 ? 9 : c)) * 4) + 1), 12'(n));
      span(1'b1, n);
      check("conversion length", 12'd8, 12'(n));
    end
  endtask
  task automatic t_oneshot(input logic [11:0] raw, input logic [11:0] off,
                           input logic [11:0] exp);
    int n;
    raw_remote    = raw;
    remote_offset = off;
    raw_local     = raw ^ 12'hFFF;
    wr(PTR_ONE_SHOT, raw[7:0]);
    for (int i = 0; i < 4 && conv_busy !== 1'b1; i++) step;
    span(1'b1, n);
    check("one-shot length", 12'd8, 12'(n));
    check("remote half", 12'd4, 12'(n_remote));
    check("result strobe", 12'd1, 12'(result_stb));
    check("remote result", exp, remote_result);
    check("local result", raw ^ 12'hFFF, local_result);
    n = 0;
    repeat (40)
    begin
      step;
      if (conv_busy !== 1'b0) n++;
    end
    check("stays shut", 12'd0, 12'(n));
  endtask
  task automatic t_gc;
    wr(PTR_INTERVAL_WR, 8'h05);
    i_host.gcall(8'h12);
    rd(PTR_INTERVAL_RD, "other second byte", 8'h05);
    wr(PTR_ONE_SHOT, 8'h00);
    step;
    check("busy before abort", 12'd1, 12'(conv_busy));
    i_host.gcall(GC_RESET_CMD);
    check("busy after abort", 12'd0, 12'(conv_busy));
    rd(PTR_INTERVAL_RD, "interval after reset", INTERVAL_RST);
    rd(PTR_IDEALITY, "ideality after reset", IDEALITY_RST);
  endtask
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_regs;
    t_gap;
    while (conv_busy !== 1'b1) step;
    shutdown_request = 1'b1;
    while (conv_busy !== 1'b0) step;
    t_oneshot(12'h828, 12'h010, 12'h7B8);
    t_gc;
    t_oneshot(12'h100, 12'hFF0, 12'h0F0);
    shutdown_request = 1'b0;
    repeat (3) step;
    check("resume", 12'd1, 12'(conv_busy));
    end_of_test;
  end
endmodule
`default_nettype wire
